// [hw/fcs_host.sv]
`timescale 1ns/100ps
// Contract
// - A byte program sends AA to 5555, 55 to 2AAA, A0 to 5555, then the byte at its address.
// - Completion may be taken after 20 us per byte, 25 ms per sector, 100 ms per bank.
// - A bank erase is AA, 55, 80, AA, 55, 10 on alternating command addresses; the code writes 80 and the next AA both to 5555.
// - A sector erase is the unlock and setup prefix, then 30 at an address in the sector.
// - Identification exit is AA, 55, F0 and normal reads follow within 150 ns.
// - On the small package the host drives the shared pin as output strobe for flash.
// - After identification entry the host waits 150 ns before reading identity bytes.
module fcs_host
    import fcs_pkg::*;
#(
    parameter int BYTE_WRITE_CYCLES = BYTE_WRITE_CYC,
    parameter int SECTOR_CLEAR_CYCLES = SECTOR_CLEAR_CYC,
    parameter int BANK_CLEAR_CYCLES = BANK_CLEAR_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // User command port
    input wire logic req_valid,
    output logic req_ready,
    input wire fcs_op_e req_op,
    input wire fcs_wait_e req_wait,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_data,
    output logic done_valid,
    output logic [DATA_W-1:0] done_data,
    output logic sram_free,
    // Flash pins
    output logic [ADDR_W-1:0] mem_addr,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [DATA_W-1:0] dq_in,
    output logic flash_bank_select_n,
    output logic write_strobe_n,
    output logic output_strobe_n
);
    typedef enum logic [2:0] {
        S_IDLE, S_WR_LOW, S_WR_HIGH, S_RD, S_WAIT, S_DONE
    } fcs_state_e;

    fcs_state_e state;
    fcs_op_e op;
    fcs_wait_e wmode;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [2:0] step;
    logic [2:0] last_step;
    logic [3:0] pcnt;
    logic have_prev;
    logic [DATA_W-1:0] prev_rd;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_count;
    logic tmr_done;
    logic [14:0] cyc_addr;
    logic [DATA_W-1:0] cyc_data;
    logic [ADDR_W-1:0] next_addr;

    fcs_timer u_timer (
        .clk(clk),
        .arst_n(arst_n),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // Command table per step; upper bits held at zero on command cycles except the sector-erase 30 cycle, which goes to the sector address
    always_comb begin
        cyc_addr = CMD_ADDR_A;
        cyc_data = CMD_UNLOCK1;
        case (step)
            3'd0: begin
                cyc_addr = CMD_ADDR_A;
                cyc_data = CMD_UNLOCK1;
            end
            3'd1, 3'd4: begin
                cyc_addr = CMD_ADDR_B;
                cyc_data = CMD_UNLOCK2;
            end
            3'd2: begin
                cyc_addr = CMD_ADDR_A;
                case (op)
                    FCS_OP_PROGRAM: cyc_data = CMD_PROGRAM;
                    FCS_OP_ID_ENTRY: cyc_data = CMD_ID_ENTRY;
                    FCS_OP_ID_EXIT: cyc_data = CMD_ID_EXIT;
                    default: cyc_data = CMD_SETUP;
                endcase
            end
            3'd3: begin
                cyc_addr = CMD_ADDR_A;
                cyc_data = CMD_UNLOCK1;
            end
            default: begin
                cyc_addr = CMD_ADDR_A;
                cyc_data = (op == FCS_OP_BANK_CLEAR) ? CMD_BANK_CLEAR : CMD_SECTOR_CLEAR;
            end
        endcase
    end

    // Last write: byte address or sector address, else command address
    always_comb begin
        next_addr = {{(ADDR_W-15){1'b0}}, cyc_addr};
        if (step == last_step && (op == FCS_OP_PROGRAM || op == FCS_OP_SECTOR_CLEAR)) begin
            next_addr = addr;
        end
    end

    always_comb begin
        case (op)
            FCS_OP_PROGRAM: last_step = 3'd3;
            FCS_OP_SECTOR_CLEAR, FCS_OP_BANK_CLEAR: last_step = 3'd5;
            FCS_OP_READ: last_step = 3'd0;
            default: last_step = 3'd2;
        endcase
    end

    always_comb begin
        case (op)
            FCS_OP_SECTOR_CLEAR: tmr_count = CNT_W'(SECTOR_CLEAR_CYCLES);
            FCS_OP_BANK_CLEAR: tmr_count = CNT_W'(BANK_CLEAR_CYCLES);
            FCS_OP_PROGRAM: tmr_count = CNT_W'(BYTE_WRITE_CYCLES);
            default: tmr_count = CNT_W'(ID_ACCESS_CYC);
        endcase
    end

    assign tmr_load = (state == S_WR_HIGH) && (pcnt == 4'd0) && (step == last_step);
    assign req_ready = (state == S_IDLE);
    // SRAM may be used while flash is busy: no flash strobe is active then
    assign sram_free = (state == S_WAIT) && flash_bank_select_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= S_IDLE;
            op <= FCS_OP_READ;
            wmode <= FCS_WAIT_TIMER;
            addr <= '0;
            data <= '0;
            step <= 3'd0;
            pcnt <= 4'd0;
            have_prev <= 1'b0;
            prev_rd <= '0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (req_valid) begin
                        op <= req_op;
                        wmode <= req_wait;
                        addr <= req_addr;
                        data <= req_data;
                        step <= 3'd0;
                        have_prev <= 1'b0;
                        pcnt <= 4'(READ_ACCESS_CYC);
                        state <= (req_op == FCS_OP_READ) ? S_RD : S_WR_LOW;
                        if (req_op != FCS_OP_READ) begin
                            pcnt <= 4'(WRITE_PULSE_CYC);
                        end
                    end
                end
                S_WR_LOW: begin
                    if (pcnt == 4'd0) begin
                        pcnt <= 4'(WRITE_HIGH_CYC);
                        state <= S_WR_HIGH;
                    end else begin
                        pcnt <= pcnt - 4'd1;
                    end
                end
                S_WR_HIGH: begin
                    if (pcnt != 4'd0) begin
                        pcnt <= pcnt - 4'd1;
                    end else if (step == last_step) begin
                        state <= S_WAIT;
                    end else begin
                        step <= step + 3'd1;
                        pcnt <= 4'(WRITE_PULSE_CYC);
                        state <= S_WR_LOW;
                    end
                end
                S_WAIT: begin
                    // Polling only makes sense for array writes
                    if (wmode == FCS_WAIT_TIMER || op == FCS_OP_ID_ENTRY
                        || op == FCS_OP_ID_EXIT) begin
                        if (tmr_done) begin
                            state <= S_DONE;
                        end
                    end else begin
                        pcnt <= 4'(READ_ACCESS_CYC);
                        state <= S_RD;
                    end
                end
                S_RD: begin
                    if (pcnt != 4'd0) begin
                        pcnt <= pcnt - 4'd1;
                    end else if (op == FCS_OP_READ) begin
                        state <= S_DONE;
                    end else if (wmode == FCS_WAIT_TOGGLE) begin
                        have_prev <= 1'b1;
                        prev_rd <= dq_in;
                        if (have_prev && prev_rd[TOGGLE_BIT] == dq_in[TOGGLE_BIT]) begin
                            state <= S_DONE;
                        end else begin
                            state <= S_WAIT;
                        end
                    end else if (dq_in[STATUS7_BIT] == (op == FCS_OP_PROGRAM ?
                                 data[STATUS7_BIT] : ERASED_BYTE[STATUS7_BIT])) begin
                        state <= S_DONE;
                    end else begin
                        state <= S_WAIT;
                    end
                end
                S_DONE: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Pin drive; writes strobed by write strobe with bank select held low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_addr <= '0;
            dq_out <= '0;
            dq_oe <= 1'b0;
            flash_bank_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            output_strobe_n <= 1'b1;
        end else begin
            write_strobe_n <= !(state == S_WR_LOW);
            flash_bank_select_n <= !(state == S_WR_LOW || state == S_RD);
            output_strobe_n <= !(state == S_RD);
            dq_oe <= (state == S_WR_LOW || state == S_WR_HIGH);
            if (state == S_WR_LOW || state == S_WR_HIGH) begin
                mem_addr <= next_addr;
                dq_out <= (op == FCS_OP_PROGRAM && step == last_step) ? data : cyc_data;
            end else if (state == S_RD) begin
                mem_addr <= addr;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            done_valid <= 1'b0;
            done_data <= '0;
        end else begin
            done_valid <= (state == S_DONE);
            if (state == S_RD && pcnt == 4'd0) begin
                done_data <= dq_in;
            end
        end
    end

    a_strobes_excl: assert property (@(posedge clk) disable iff (!arst_n)
        !(write_strobe_n == 1'b0 && output_strobe_n == 1'b0))
        else $error("write and output strobe both low");
    a_bank_with_write: assert property (@(posedge clk) disable iff (!arst_n)
        !write_strobe_n |-> !flash_bank_select_n && dq_oe)
        else $error("write strobe without bank select or data");
    a_first_unlock: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(write_strobe_n) && $past(state, 2) == S_IDLE |->
        mem_addr[14:0] == CMD_ADDR_A && dq_out == CMD_UNLOCK1)
        else $error("first command cycle wrong");
    a_cmd_upper_zero: assert property (@(posedge clk) disable iff (!arst_n)
        !write_strobe_n && !(step == last_step && op != FCS_OP_BANK_CLEAR
        && op != FCS_OP_ID_ENTRY && op != FCS_OP_ID_EXIT) |-> mem_addr[ADDR_W-1:15] == '0)
        else $error("command cycle upper address not zero");
    a_sram_idle: assert property (@(posedge clk) disable iff (!arst_n)
        sram_free |-> write_strobe_n && output_strobe_n)
        else $error("flash strobes active while sram free");
    a_timer_wait: assert property (@(posedge clk) disable iff (!arst_n)
        state == S_WAIT && wmode == FCS_WAIT_TIMER && !tmr_done |=> state != S_DONE)
        else $error("finished before wait time");
    a_id_wait: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(state == S_WAIT) && op == FCS_OP_ID_ENTRY |=> state == S_WAIT [*7])
        else $error("identity wait too short");
    a_toggle_done: assert property (@(posedge clk) disable iff (!arst_n)
        state == S_RD && pcnt == 4'd0 && wmode == FCS_WAIT_TOGGLE && op != FCS_OP_READ
        && !have_prev |=> state == S_WAIT)
        else $error("toggle poll ended after one read");
endmodule

// [hw/fcs_pkg.sv]
package fcs_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int CLK_MHZ = 50;

    // Command addresses and data
    localparam logic [14:0] CMD_ADDR_A = 15'h5555;
    localparam logic [14:0] CMD_ADDR_B = 15'h2AAA;
    localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_SETUP = 8'h80;
    localparam logic [7:0] CMD_BANK_CLEAR = 8'h10;
    localparam logic [7:0] CMD_SECTOR_CLEAR = 8'h30;
    localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int STATUS7_BIT = 7;
    localparam int TOGGLE_BIT = 6;

    // Timing, in printed units
    localparam int BYTE_WRITE_TIME_US = 20;
    localparam int SECTOR_CLEAR_TIME_MS = 25;
    localparam int BANK_CLEAR_TIME_MS = 100;
    localparam int ID_ACCESS_TIME_NS = 150;
    localparam int WRITE_PULSE_NS = 40;
    localparam int WRITE_HIGH_NS = 30;
    localparam int READ_ACCESS_NS = 70;

    localparam int BYTE_WRITE_CYC = BYTE_WRITE_TIME_US * CLK_MHZ;
    localparam int SECTOR_CLEAR_CYC = SECTOR_CLEAR_TIME_MS * 1000 * CLK_MHZ;
    localparam int BANK_CLEAR_CYC = BANK_CLEAR_TIME_MS * 1000 * CLK_MHZ;
    localparam int ID_ACCESS_CYC = (ID_ACCESS_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000 + 1;

    localparam int CNT_W = 24;

    typedef enum logic [2:0] {
        FCS_OP_PROGRAM,
        FCS_OP_SECTOR_CLEAR,
        FCS_OP_BANK_CLEAR,
        FCS_OP_ID_ENTRY,
        FCS_OP_ID_EXIT,
        FCS_OP_READ
    } fcs_op_e;

    typedef enum logic [1:0] {
        FCS_WAIT_TIMER,
        FCS_WAIT_TOGGLE,
        FCS_WAIT_STATUS7
    } fcs_wait_e;
endpackage

// [hw/fcs_timer.sv]
`timescale 1ns/100ps
module fcs_timer
    import fcs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control
    input wire logic load,
    input wire logic [CNT_W-1:0] count,
    output logic done
);
    logic [CNT_W-1:0] remain;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (remain != '0) begin
            remain <= remain - CNT_W'(1);
        end
    end

    assign done = (remain == '0) && !load;

    a_timer_reload: assert property (@(posedge clk) disable iff (!arst_n)
        load && count > CNT_W'(1) |=> !done)
        else $error("timer ended right after load");
endmodule

// [dv/fcs_flash_model.sv]
`timescale 1ns/100ps
module fcs_flash_model
    import fcs_pkg::*;
#(
    parameter int BYTE_NS = 440,
    parameter int SECTOR_NS = 640,
    parameter int BANK_NS = 840,
    parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'hC3 // Arbitrary value
) (
    // Flash pins
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic flash_bank_select_n,
    input wire logic write_strobe_n,
    input wire logic output_strobe_n,
    // Data toward the host
    output logic [DATA_W-1:0] dq_drv
);
    logic [7:0] mem [int];
    logic [7:0] true_data = 8'h00;
    logic [7:0] last = 8'h00;
    logic [7:0] rdata;
    logic busy = 1'b0;
    logic id_mode = 1'b0;
    logic tog = 1'b0;
    int step = 0;
    // Whichever strobe rises first ends the write
    wire wr_n = write_strobe_n | flash_bank_select_n;
    wire rd = !flash_bank_select_n && !output_strobe_n && write_strobe_n;
    wire [14:0] cmd_addr = mem_addr[14:0];
    wire hit_a = cmd_addr == CMD_ADDR_A;
    wire hit_b = cmd_addr == CMD_ADDR_B;

    task automatic start(input int ns, input int a, input logic [7:0] d, input int kind);
        true_data = d;
        busy = 1'b1;
        step = 0;
        // Runs on its own, so the SRAM side stays usable meanwhile
        fork
            begin
                #(ns);
                if (kind == 0)
                    mem[a] = d;
                else
                    foreach (mem[k])
                        if (kind == 2 || k[18:12] == a[18:12])
                            mem[k] = ERASED_BYTE;
                busy = 1'b0;
            end
        join_none
    endtask

    always @(posedge wr_n) begin
        if (!busy) begin
            case (step)
                0, 3: step = (hit_a && dq_out == CMD_UNLOCK1) ? step + 1 : 0;
                1, 4: step = (hit_b && dq_out == CMD_UNLOCK2) ? step + 1 : 0;
                2: begin
                    step = 0;
                    if (hit_a && dq_out == CMD_PROGRAM) step = 10;
                    if (hit_a && dq_out == CMD_SETUP) step = 3;
                    if (hit_a && dq_out == CMD_ID_ENTRY) id_mode = 1'b1;
                    if (hit_a && dq_out == CMD_ID_EXIT) id_mode = 1'b0;
                end
                5: begin
                    step = 0;
                    if (hit_a && dq_out == CMD_BANK_CLEAR) start(BANK_NS, 0, ERASED_BYTE, 2);
                    if (dq_out == CMD_SECTOR_CLEAR)
                        start(SECTOR_NS, int'(mem_addr), ERASED_BYTE, 1);
                end
                10: start(BYTE_NS, int'(mem_addr), dq_out, 0);
                default: step = 0;
            endcase
        end
    end

    always @* begin
        if (busy) rdata = {~true_data[7], tog, 6'h00};
        else if (id_mode && mem_addr[18:1] == '0)
            rdata = mem_addr[0] ? PART_CODE : MAKER_CODE;
        else if (mem.exists(int'(mem_addr))) rdata = mem[int'(mem_addr)];
        else rdata = ERASED_BYTE;
    end

    // A released bus shows the inverse of the last byte, so stale data never matches
    assign dq_drv = rd ? rdata : ~last;
    always @(negedge rd) begin
        last = rdata;
        if (busy) tog = ~tog;
    end
endmodule

// [dv/flash_command_sequencer_bench.sv]
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); miscompares++; end end
module flash_command_sequencer_bench;
    import fcs_pkg::*;
    localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
    localparam logic [7:0] PART = 8'hC3; // Arbitrary value
    localparam int CLK_NS = 20;
    // Model takes the full worst-case time, so a short timer wait reads status, not data
    localparam int BYTE_CYC = 20;
    localparam int SECTOR_CYC = 30;
    localparam int BANK_CYC = 40;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid = 1'b0;
    fcs_op_e req_op = FCS_OP_READ;
    fcs_wait_e req_wait = FCS_WAIT_TIMER;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_data = '0;
    logic req_ready, done_valid, sram_free, dq_oe;
    logic flash_bank_select_n, write_strobe_n, output_strobe_n;
    logic [DATA_W-1:0] done_data, dq_out, dq_in, mdl_dq;
    logic [ADDR_W-1:0] mem_addr;
    int miscompares = 0;
    int cmp_count = 0;
    int free_cyc = 0;
    int clash = 0;

    always #10 clk = ~clk;
    assign dq_in = dq_oe ? dq_out : mdl_dq;

    fcs_host #(
        .BYTE_WRITE_CYCLES(BYTE_CYC),
        .SECTOR_CLEAR_CYCLES(SECTOR_CYC),
        .BANK_CLEAR_CYCLES(BANK_CYC)
    ) dut_u (
        .clk, .arst_n, .req_valid, .req_ready, .req_op, .req_wait, .req_addr, .req_data,
        .done_valid, .done_data, .sram_free, .mem_addr, .dq_out, .dq_oe, .dq_in,
        .flash_bank_select_n, .write_strobe_n, .output_strobe_n
    );
    fcs_flash_model #(
        .BYTE_NS(BYTE_CYC * CLK_NS),
        .SECTOR_NS(SECTOR_CYC * CLK_NS),
        .BANK_NS(BANK_CYC * CLK_NS),
        .MAKER_CODE(MAKER),
        .PART_CODE(PART)
    ) flash_u (
        .mem_addr, .dq_out, .flash_bank_select_n, .write_strobe_n, .output_strobe_n,
        .dq_drv(mdl_dq)
    );

    task automatic final_report();
        if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic run_op(input fcs_op_e op, input fcs_wait_e w,
            input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(posedge clk);
        #1;
        req_op = op;
        req_wait = w;
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        // Request stands until an edge that finds the block ready
        for (n = 0; n < 3000 && req_ready !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (req_ready !== 1'b1) begin
            miscompares++;
            final_report();
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        for (n = 0; n < 3000 && done_valid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
            if (sram_free === 1'b1) free_cyc++;
            if (sram_free === 1'b1 && (flash_bank_select_n & write_strobe_n) !== 1'b1) clash++;
        end
        if (done_valid !== 1'b1) begin
            miscompares++;
            final_report();
        end
    endtask

    task automatic check_read(input string nm, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] exp);
        run_op(FCS_OP_READ, FCS_WAIT_TIMER, a, 8'h00);
        `CHK(nm, exp, done_data)
    endtask

    // One byte per wait style; bit seven set for status polling
    task automatic t_program();
        logic [DATA_W-1:0] pat [3] = '{8'h5A, 8'hA5, 8'h81};
        for (int i = 0; i < 3; i++) begin
            run_op(FCS_OP_PROGRAM, fcs_wait_e'(i), 19'h1_2340 + 19'(i), pat[i]);
            check_read("program readback", 19'h1_2340 + 19'(i), pat[i]);
        end
        `CHK("sram free seen", 1'b1, free_cyc > 0)
        `CHK("flash idle while free", 0, clash)
    endtask

    task automatic t_sector();
        run_op(FCS_OP_PROGRAM, FCS_WAIT_STATUS7, 19'h0_3005, 8'h11);
        run_op(FCS_OP_PROGRAM, FCS_WAIT_STATUS7, 19'h0_4005, 8'h22);
        run_op(FCS_OP_SECTOR_CLEAR, FCS_WAIT_TIMER, 19'h0_3FFF, 8'h00);
        check_read("erased sector", 19'h0_3005, ERASED_BYTE);
        check_read("kept sector", 19'h0_4005, 8'h22);
        run_op(FCS_OP_SECTOR_CLEAR, FCS_WAIT_STATUS7, 19'h0_4000, 8'h00);
        check_read("second sector", 19'h0_4005, ERASED_BYTE);
    endtask

    task automatic t_bank();
        run_op(FCS_OP_PROGRAM, FCS_WAIT_TOGGLE, 19'h7_FFFF, 8'h00);
        run_op(FCS_OP_BANK_CLEAR, FCS_WAIT_TOGGLE, 19'h0_0000, 8'h00);
        check_read("bank erased", 19'h7_FFFF, ERASED_BYTE);
        run_op(FCS_OP_PROGRAM, FCS_WAIT_TIMER, 19'h0_0000, 8'h42);
        run_op(FCS_OP_BANK_CLEAR, FCS_WAIT_TIMER, 19'h0_0000, 8'h00);
        check_read("bank erased timed", 19'h0_0000, ERASED_BYTE);
    endtask

    task automatic t_ident();
        run_op(FCS_OP_PROGRAM, FCS_WAIT_STATUS7, 19'h0_0001, 8'h42);
        run_op(FCS_OP_ID_ENTRY, FCS_WAIT_TIMER, 19'h0_0000, 8'h00);
        check_read("maker code", 19'h0_0000, MAKER);
        check_read("part code", 19'h0_0001, PART);
        run_op(FCS_OP_ID_EXIT, FCS_WAIT_TIMER, 19'h0_0000, 8'h00);
        check_read("array after exit", 19'h0_0001, 8'h42);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_program();
        t_sector();
        t_bank();
        t_ident();
        final_report();
    end
endmodule
